// *** rtl/rtc_alarm_regs.svh ***
`ifndef RTC_ALARM_REGS_SVH
`define RTC_ALARM_REGS_SVH
// Register indices; byte address is four times the index
`define IDX_HUND 5'h00
`define IDX_ALM0 5'h08
`define IDX_INTR 5'h10
`define IDX_CMD 5'h11
// Command bit positions
`define CMD_FSEL_LO 0
`define CMD_RUN 3
`define CMD_IE 4
`define CMD_TEST 5
// Status bit positions
`define ST_ALARM 0
`define ST_HUND 1
`define ST_TENTH 2
`define ST_SEC 3
`define ST_MIN 4
`define ST_HOUR 5
`define ST_DAY 6
`define ST_GLOBAL 7
// Reset values
`define CMD_RST 6'h00
`define MASK_RST 7'h00
// Timing counts
`define TICK_HZ 23'd4000
`define DIV_100 6'd40
`define DIV_10 4'd10
`define OSC_F0 23'd32768
`define OSC_F1 23'd1048576
`define OSC_F2 23'd2097152
`define OSC_F3 23'd4194304
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/rtc_alarm_pkg.sv ***
package rtc_alarm_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    fsel_32k = 2'h0,
    fsel_1m = 2'h1,
    fsel_2m = 2'h2,
    fsel_4m = 2'h3
  } fsel_t;
endpackage : rtc_alarm_pkg

// *** rtl/rtc_alarm_interrupt_latch.sv ***
// Function
// [R01] Alarm memory of 51 bits, one word per counter.
// [R02] Alarm flag when all unmasked alarm words equal their counters.
// [R03] Mask bit at 1 drops that word from the compare.
// [R04] Six periodic sources: 100Hz, 10Hz, second, minute, hour, day.
// [R05] 100Hz and 10Hz by fractional division, zero average error.
// [R06] Periodic and alarm events both feed the interrupt independently.
// [R07] Mask bits D1..D6 enable the matching periodic status bits.
// [R08] Status read returns cause flags and clears them.
// [R09] Flags set on every increment or match, mask regardless.
// [R10] Host checks slowest enabled flag first.
// [R11] D7 set when the interrupt was really driven.
// [R12] Interrupt armed only with enable bit and some mask bit set.
// [R13] Masked flag setting turns interrupt on and sets global flag.
// [R14] Status read releases the interrupt output.
// [R15] Interrupts continue during backup supply.
// [R16] Power fail blocks all bus reads and writes.
// [R17] Backup operation limited to timekeeping and interrupts.
// [R18] Run bit gates the 100Hz tick; stopped counters freeze.
// [R19] Host stops, writes time, then starts the clock.
// [R20] Hundredths read snapshots all counters for later reads.
// [R21] Tick during a read is postponed until the read ends.
// [R22] Host keeps read strobes under 0.01s.
// [R23] Oscillator divided to 4000Hz by selected ratio, then to 100Hz.
// [R24] Status layout: alarm, hundredths..day, global in D7.
// [R25] Mask bit D3 enables once-per-second interrupt.
// [R26] Unused bits read zero and are ignored on write.
// [R27] Event coinciding with clearing read keeps its flag.
// [R28] Alarm flag once per match, on the matching tick.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.svh"
module rtc_alarm_interrupt_latch import rtc_alarm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic osc_pin,
  input wire logic pwr_fail_pin,
  output logic irq_out,
  output logic irq_oe,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Word layout tables
  // ****************************************
  // Order: hund, hours, min, sec, month, date, year, weekday
  localparam logic [63:0] CNT_W = 64'h7F1F3F3F0F1F7F07;
  localparam logic [63:0] ALM_W = 64'hFF5FBFBF8F9FFF87;
  localparam logic [63:0] M_BIT = 64'h8040808080808080;
  localparam logic [63:0] CNT_MAX = 64'h63173B3B0C1F6306;
  localparam logic [63:0] CNT_MIN = 64'h0000000001010000;
  function automatic byte_t tb8(input logic [63:0] t, input int i);
    tb8 = t[63-8*i -: 8];
  endfunction : tb8

  byte_t cnt_ff [8];
  byte_t alm_ff [8]; // [R01]
  byte_t snap_ff [8];
  logic [5:0] cmd_ff;
  logic [6:0] mask_ff;
  logic [7:0] stat_ff;
  logic irq_ff;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; value moves once stages two and three agree
  logic [2:0] osc_s_ff;
  logic [2:0] pf_s_ff;
  logic osc_lvl_ff;
  logic pf_lvl_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      osc_s_ff <= 3'h0;
      pf_s_ff <= 3'h0;
      osc_lvl_ff <= 1'b0;
      pf_lvl_ff <= 1'b0;
    end else begin
      osc_s_ff <= {osc_s_ff[1:0], osc_pin};
      pf_s_ff <= {pf_s_ff[1:0], pwr_fail_pin};
      if (osc_s_ff[1] == osc_s_ff[2]) osc_lvl_ff <= osc_s_ff[2];
      if (pf_s_ff[1] == pf_s_ff[2]) pf_lvl_ff <= pf_s_ff[2];
    end
  end
  logic osc_rise;
  assign osc_rise = (osc_s_ff[1] == osc_s_ff[2]) && osc_s_ff[2] && !osc_lvl_ff;

  // ****************************************
  // Tick dividers
  // ****************************************
  // Fractional accumulator: crystal rates are powers of two
  logic [22:0] acc_ff;
  logic [22:0] nxt_acc;
  logic [22:0] fdiv;
  logic [5:0] div100_ff;
  logic tick100_ff;
  always_comb begin
    case (fsel_t'(cmd_ff[`CMD_FSEL_LO +: 2]))
      fsel_32k: fdiv = `OSC_F0;
      fsel_1m: fdiv = `OSC_F1;
      fsel_2m: fdiv = `OSC_F2;
      default: fdiv = `OSC_F3;
    endcase
    nxt_acc = acc_ff + `TICK_HZ;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_ff <= 23'h0;
      div100_ff <= 6'h0;
      tick100_ff <= 1'b0;
    end else begin
      tick100_ff <= 1'b0;
      if (cmd_ff[`CMD_TEST]) begin
        tick100_ff <= osc_rise & cmd_ff[`CMD_RUN]; // [R18]
      end else if (osc_rise) begin
        if (nxt_acc >= fdiv) begin // [R05] [R23]
          acc_ff <= nxt_acc - fdiv;
          if (div100_ff == `DIV_100 - 6'd1) begin
            div100_ff <= 6'h0;
            tick100_ff <= cmd_ff[`CMD_RUN]; // [R18]
          end else begin
            div100_ff <= div100_ff + 6'd1;
          end
        end else begin
          acc_ff <= nxt_acc;
        end
      end
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_held_ff;
  logic w_held_ff;
  logic [4:0] aw_idx_ff;
  byte_t wd_ff;
  logic wen_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  byte_t rdata_ff;
  logic do_wr;
  logic do_rd;
  logic [4:0] ar_idx;
  assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[6:2];
  // Address and data taken in either order, held until answered
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 5'h0;
      wd_ff <= 8'h0;
      wen_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[6:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wd_ff <= s_axi_wdata[7:0];
        wen_ff <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (pf_lvl_ff || aw_idx_ff > `IDX_CMD) ? `RESP_SLVERR : `RESP_OKAY; // [R16]
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  logic wr_ok;
  assign wr_ok = do_wr && wen_ff && !pf_lvl_ff; // [R16] [R17]

  // Read answer one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 8'h0;
    end else if (do_rd) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 8'h0; // [R26]
      if (pf_lvl_ff || ar_idx > `IDX_CMD) begin
        rresp_ff <= `RESP_SLVERR; // [R16]
      end else if (ar_idx == `IDX_HUND) begin
        rdata_ff <= cnt_ff[0];
      end else if (ar_idx < `IDX_ALM0) begin
        rdata_ff <= snap_ff[ar_idx[2:0]]; // [R20]
      end else if (ar_idx < `IDX_INTR) begin
        rdata_ff <= alm_ff[ar_idx[2:0]];
      end else if (ar_idx == `IDX_INTR) begin
        rdata_ff <= stat_ff; // [R08]
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h0, rdata_ff};

  logic hund_rd;
  logic stat_rd;
  assign hund_rd = do_rd && !pf_lvl_ff && ar_idx == `IDX_HUND;
  assign stat_rd = do_rd && !pf_lvl_ff && ar_idx == `IDX_INTR;

  // ****************************************
  // Counters and snapshot
  // ****************************************
  // Tick held back while a read answer is on the bus
  logic pend_ff;
  logic step;
  logic step_d_ff;
  assign step = !rvalid_ff && (tick100_ff || pend_ff); // [R21]
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pend_ff <= 1'b0;
      step_d_ff <= 1'b0;
    end else begin
      pend_ff <= rvalid_ff && (tick100_ff || pend_ff); // [R21]
      step_d_ff <= step;
    end
  end

  // Carry chain: each word rolls when all faster words roll
  logic [7:0] roll;
  logic [6:0] ev;
  always_comb begin
    roll[0] = step;
    for (int i = 1; i < 8; i++) roll[i] = 1'b0;
    roll[3] = step && cnt_ff[0] == tb8(CNT_MAX, 0);
    roll[2] = roll[3] && cnt_ff[3] == tb8(CNT_MAX, 3);
    roll[1] = roll[2] && cnt_ff[2] == tb8(CNT_MAX, 2);
    roll[5] = roll[1] && cnt_ff[1] == tb8(CNT_MAX, 1);
    roll[7] = roll[5];
    roll[4] = roll[5] && cnt_ff[5] == tb8(CNT_MAX, 5);
    roll[6] = roll[4] && cnt_ff[4] == tb8(CNT_MAX, 4);
    ev = 7'h0;
    ev[`ST_HUND] = step; // [R04] [R24]
    ev[`ST_TENTH] = step && (cnt_ff[0] % 8'd10) == 8'd9;
    ev[`ST_SEC] = roll[3];
    ev[`ST_MIN] = roll[2];
    ev[`ST_HOUR] = roll[1];
    ev[`ST_DAY] = roll[5];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) cnt_ff[i] <= tb8(CNT_MIN, i);
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_ok && aw_idx_ff == 5'(i)) begin
          cnt_ff[i] <= wd_ff & tb8(CNT_W, i); // [R26]
        end else if (roll[i]) begin
          cnt_ff[i] <= (cnt_ff[i] == tb8(CNT_MAX, i)) ?
            tb8(CNT_MIN, i) : cnt_ff[i] + 8'd1; // [R18]
        end
      end
    end
  end

  // Snapshot keeps a coherent set for the slower words
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) snap_ff[i] <= 8'h0;
    end else if (hund_rd) begin
      for (int i = 0; i < 8; i++) snap_ff[i] <= cnt_ff[i]; // [R20]
    end
  end

  // ****************************************
  // Alarm memory and compare
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) alm_ff[i] <= 8'h0;
    end else if (wr_ok && aw_idx_ff[4:3] == 2'b01) begin
      alm_ff[aw_idx_ff[2:0]] <= wd_ff & tb8(ALM_W, 32'(aw_idx_ff[2:0])); // [R01]
    end
  end

  logic match;
  always_comb begin
    match = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if ((alm_ff[i] & tb8(M_BIT, i)) == 8'h0 &&
          (alm_ff[i] & tb8(CNT_W, i)) != cnt_ff[i]) begin
        match = 1'b0; // [R02] [R03]
      end
    end
  end
  logic alarm_ev;
  assign alarm_ev = step_d_ff && match; // [R28]

  // ****************************************
  // Status, mask, command, interrupt
  // ****************************************
  logic [6:0] set_v;
  logic armed;
  logic fire;
  assign set_v = {ev[6:1], alarm_ev}; // [R06] [R09]
  assign armed = cmd_ff[`CMD_IE] && (|mask_ff); // [R12]
  assign fire = armed && (|(set_v & mask_ff)); // [R07] [R13] [R25]

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmd_ff <= `CMD_RST;
      mask_ff <= `MASK_RST;
    end else if (wr_ok) begin
      if (aw_idx_ff == `IDX_CMD) cmd_ff <= wd_ff[5:0];
      if (aw_idx_ff == `IDX_INTR) mask_ff <= wd_ff[6:0];
    end
  end

  // Set wins over the clearing read so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_ff <= 8'h0;
    end else begin
      stat_ff[6:0] <= (stat_rd ? 7'h0 : stat_ff[6:0]) | set_v; // [R08] [R09] [R27]
      stat_ff[`ST_GLOBAL] <= fire || (!stat_rd && stat_ff[`ST_GLOBAL]); // [R11]
    end
  end

  // Open-drain output: pin driven low while enabled
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= fire || (!stat_rd && irq_ff); // [R13] [R14] [R15]
    end
  end
  assign irq_oe = irq_ff;
  assign irq_out = 1'b0;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_tick_in_read;
    tick100_ff && rvalid_ff;
  endsequence
  // Held tick followed by the read answer leaving the bus
  sequence s_read_ends;
    s_tick_in_read ##1 !rvalid_ff;
  endsequence
  chk_tick_postpone: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_tick_in_read |-> !step ##[1:300] (step || !rst_b)) // [R21]
    else $error("tick not postponed during read");
  chk_stopped_freeze: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cmd_ff[`CMD_RUN] && !pend_ff && !tick100_ff |=> !roll[0]) // [R18]
    else $error("counter stepped while stopped");
  chk_irq_fire: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fire |=> irq_oe && stat_ff[`ST_GLOBAL]) // [R13]
    else $error("interrupt not raised on masked flag");
  chk_irq_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stat_rd && !fire |=> !irq_oe && !stat_ff[`ST_GLOBAL]) // [R14]
    else $error("interrupt not released by status read");
  chk_irq_unarmed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(irq_oe) |-> $past(cmd_ff[`CMD_IE]) && $past(|mask_ff)) // [R12]
    else $error("interrupt without enable");
  chk_flag_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stat_rd && set_v[`ST_HUND] |=> stat_ff[`ST_HUND]) // [R27]
    else $error("event lost on clearing read");
  chk_pf_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
    do_rd && pf_lvl_ff |=> s_axi_rresp == `RESP_SLVERR) // [R16]
    else $error("read not blocked in power fail");
  chk_snap_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !hund_rd |=> snap_ff[3] == $past(snap_ff[3])) // [R20]
    else $error("snapshot changed without hundredths read");
  chk_alarm_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alarm_ev |=> !alarm_ev) // [R28]
    else $error("alarm flagged twice for one match");
  chk_read_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_ends |-> step) // [R21]
    else $error("held tick not applied after read");
endmodule : rtc_alarm_interrupt_latch
`default_nettype wire

// *** testbench/osc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Oscillator source and interrupt line
// ****************************************
module osc_partner (
  input wire logic sys_clk,
  input wire logic irq_out,
  input wire logic irq_oe,
  output logic osc_pin,
  output wire logic irq_n
);
  // Pull-up holds the open-drain line high once released
  assign irq_n = irq_oe ? irq_out : 1'b1;
  initial osc_pin = 1'b0;
  // Stands low between bursts so no stray tick reaches the counters
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      osc_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      osc_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : pulses
endmodule : osc_partner
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.svh"
module tb import rtc_alarm_pkg::*;;
  logic sys_clk, rst_b, osc_pin, pwr_fail_pin, irq_out, irq_oe, irq_n;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0;
  int samples_checked = 0;
  rtc_alarm_interrupt_latch dut_u (.sys_clk, .rst_b, .osc_pin, .pwr_fail_pin, .irq_out, .irq_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  osc_partner osc_u (.sys_clk, .irq_out, .irq_oe, .osc_pin, .irq_n);
  // ****************************************
  // Clock, checks and closing
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // ****************************************
  // Register bus master
  // ****************************************
  // Address and data offered together, each released when taken
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Ready held high so the read strobe stays short
  task automatic rd(input logic [4:0] idx);
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    while (s_axi_arready !== 1'b1) @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic tick(input int n);
    osc_u.pulses(n);
    repeat (8) @(posedge sys_clk); // Sync, step, flag and irq stages
  endtask : tick
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_b, pwr_fail_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`IDX_INTR);
    chk(rdat, 32'h00000000);
    rd(`IDX_CMD);
    chk(rdat, 32'h00000000);
    rd(5'h12);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    $display("test reset done");
    // Stop, load, then start
    wr(`IDX_CMD, 8'h20);
    wr(`IDX_HUND, 8'h09);
    tick(3);
    rd(`IDX_HUND);
    chk(rdat, 32'h00000009);
    wr(`IDX_CMD, 8'h28);
    tick(3);
    rd(`IDX_HUND);
    chk(rdat, 32'h0000000C);
    chk(32'(irq_oe), 32'h0);
    rd(`IDX_INTR);
    chk(32'(rdat[`ST_HUND]), 32'h1);
    rd(`IDX_INTR);
    chk(rdat, 32'h00000000);
    $display("test run gate done");
    // Masked periodic flag drives the pin until status is read
    wr(`IDX_INTR, 8'h02);
    wr(`IDX_CMD, 8'h38);
    tick(1);
    chk(32'(irq_oe), 32'h1);
    chk(32'(irq_n), 32'h0);
    rd(`IDX_INTR);
    chk(rdat & 32'h00000083, 32'h00000082);
    @(posedge sys_clk);
    chk(32'(irq_oe), 32'h0);
    wr(`IDX_CMD, 8'h28);
    tick(1);
    chk(32'(irq_oe), 32'h0);
    rd(`IDX_INTR);
    chk(rdat & 32'h00000082, 32'h00000002);
    $display("test interrupt done");
    // Only the hundredths alarm word takes part in the compare
    wr(`IDX_CMD, 8'h20);
    wr(`IDX_HUND, 8'h05);
    for (int i = 9; i < 16; i++) wr(5'(i), (i == 9) ? 8'h40 : 8'h80);
    wr(`IDX_ALM0, 8'h07);
    wr(`IDX_INTR, 8'h01);
    wr(`IDX_CMD, 8'h38);
    rd(`IDX_INTR);
    tick(1);
    chk(32'(irq_oe), 32'h0);
    tick(1);
    chk(32'(irq_oe), 32'h1);
    rd(`IDX_INTR);
    chk(rdat & 32'h00000083, 32'h00000083);
    tick(1);
    rd(`IDX_INTR);
    chk(32'(rdat[`ST_ALARM]), 32'h0);
    $display("test alarm done");
    // Snapshot holds until hundredths is read again
    wr(`IDX_CMD, 8'h20);
    wr(5'h03, 8'h11);
    rd(`IDX_HUND);
    wr(5'h03, 8'h22);
    rd(5'h03);
    chk(rdat, 32'h00000011);
    rd(`IDX_HUND);
    rd(5'h03);
    chk(rdat, 32'h00000022);
    $display("test snapshot done");
    // Supply loss locks the bus out
    pwr_fail_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    wr(`IDX_HUND, 8'h33);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    rd(`IDX_HUND);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    chk(rdat, 32'h00000000);
    pwr_fail_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd(`IDX_HUND);
    chk(rdat, 32'h00000008);
    $display("test power fail done");
    // Minute interrupt: host looks at the slowest enabled flag first
    wr(`IDX_CMD, 8'h20);
    wr(`IDX_HUND, 8'h63);
    wr(5'h03, 8'h3B);
    wr(`IDX_INTR, 8'h10);
    wr(`IDX_CMD, 8'h38);
    rd(`IDX_INTR);
    tick(1);
    chk(32'(irq_oe), 32'h1);
    rd(`IDX_INTR);
    chk(32'(rdat[`ST_MIN]), 32'h1);
    chk(rdat & 32'h0000001E, 32'h0000001E);
    rd(`IDX_HUND);
    rd(5'h02);
    chk(rdat, 32'h00000001);
    $display("test slow flag done");
    complete_run();
  end
  // Generous bound on the whole sequence
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
